// [agc_map.svh]
// Register offsets, field positions, reset values and timing counts of the gain loop
`ifndef AGC_MAP_SVH
`define AGC_MAP_SVH
`define AGC_CTRL_OFF 12'h000
`define AGC_SHIFT_OFF 12'h004
`define AGC_GATECNT_OFF 12'h008
`define AGC_PRELOAD_OFF 12'h00C
`define AGC_STATUS_OFF 12'h010
`define AGC_LUT_BASE 12'h100
`define AGC_CTRL_MODE_LSB 0
`define AGC_CTRL_EXPINH_BIT 2
`define AGC_CTRL_CHAN_BIT 3
`define AGC_CTRL_RESET 32'h0000_0000
`define AGC_SHIFT_RESET 4'h0
`define AGC_GATECNT_RESET 16'h0100
`define AGC_DET_SHIFT 4
`define AGC_INT_FRAC 16
`endif

// [agc_pkg.sv]
// Types shared by the gain loop files
package agc_pkg;
	typedef enum logic [1:0] {
		AGC_FREE_RUN,
		AGC_GATE_LEVEL,
		AGC_GATE_EDGE,
		AGC_HOLD
	} agc_mode_t;
endpackage

// [agc_lut_mem.sv]
// Error lookup table memory with registered read data
module agc_lut_mem #(
	parameter int AW = 6,
	parameter int DW = 16
) (
	input wire logic aclk,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [DW-1:0] wdata,
	input wire logic [AW-1:0] raddr,
	output logic [DW-1:0] rdata
);
	logic [DW-1:0] mem [0:(1<<AW)-1];
	always_ff @(posedge aclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule

// [agc_gain_loop.sv]
// Dual channel automatic gain control loop with AXI4-Lite configuration
// How it works
// - Each channel has independent detector, table, integrator.
// - Absolute value then lowpass forms power estimate.
// - Filtered power indexes programmable error table.
// - Integrated error drives 3-bit amplifier gain word.
// - Shifter scales error in power-of-two steps.
// - Wide deadband yields hysteresis via table zero band.
// - Free-run mode keeps loop closed always.
// - Gated modes update only while the gate window is open: pin high (level) or counter running (edge).
// - Level gate keeps loop active during pulse.
// - Edge gate starts counter; opens at terminal.
// - Register write preloads integrator between active periods.
// - Software reads back final integrator gain.
// - Exponent output is gain complement unless inhibited.
//
// Implementation choices: the AXI4-Lite register port and the register offsets.
`include "agc_map.svh"
module agc_gain_loop #(
	parameter int NCH = 2,
	parameter int SW = 12,
	parameter int LUT_AW = 6
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [NCH*SW-1:0] sample_in,
	input wire logic [NCH-1:0] sample_valid,
	input wire logic [NCH-1:0] gate_in,
	output logic [NCH*3-1:0] amp_gain_word,
	output logic [NCH*3-1:0] comp_exponent,
	output logic [NCH-1:0] loop_active,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	localparam int IW = 3 + `AGC_INT_FRAC;
	if (NCH < 1 || NCH > 2 || SW < 8 || SW > 16 || LUT_AW < 2 || LUT_AW > 6) begin : g_param_check
		$error("agc_gain_loop: unsupported parameters");
	end

	function automatic logic [SW-1:0] abs_val(input logic [SW-1:0] x);
		abs_val = x[SW-1] ? (~x + 1'b1) : x;
	endfunction

	// AXI4-Lite write path: take address and data in either order
	logic aw_have_reg, aw_have_next, w_have_reg, w_have_next, bvalid_reg, bvalid_next;
	logic [11:0] awaddr_reg, awaddr_next;
	logic [31:0] wdata_reg, wdata_next;
	logic [1:0] bresp_reg, bresp_next;
	logic wr_fire, wr_ok;
	assign s_axi_awready = !aw_have_reg && !bvalid_reg;
	assign s_axi_wready = !w_have_reg && !bvalid_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	always_comb begin
		aw_have_next = aw_have_reg;
		w_have_next = w_have_reg;
		awaddr_next = awaddr_reg;
		wdata_next = wdata_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		wr_fire = 1'b0;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_have_next = 1'b1;
			awaddr_next = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_have_next = 1'b1;
			wdata_next = s_axi_wdata;
		end
		if (aw_have_reg && w_have_reg) begin
			wr_fire = 1'b1;
			aw_have_next = 1'b0;
			w_have_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = wr_ok ? 2'h0 : 2'h2;
		end
		if (bvalid_reg && s_axi_bready) begin
			bvalid_next = 1'b0;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			awaddr_reg <= 12'h000;
			wdata_reg <= 32'h0000_0000;
			bvalid_reg <= 1'b0;
			bresp_reg <= 2'h0;
		end else begin
			aw_have_reg <= aw_have_next;
			w_have_reg <= w_have_next;
			awaddr_reg <= awaddr_next;
			wdata_reg <= wdata_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
		end
	end

	// Configuration registers, one set per channel selected by address bit 9
	logic [1:0] mode_reg [NCH], mode_next [NCH];
	logic expinh_reg [NCH], expinh_next [NCH];
	logic [3:0] shift_reg [NCH], shift_next [NCH];
	logic [15:0] gatecnt_reg [NCH], gatecnt_next [NCH];
	logic [NCH-1:0] preload_pulse, lut_we;
	logic wr_ch, rd_ch;
	logic [11:0] wr_off, rd_off;
	assign wr_ch = awaddr_reg[9];
	assign wr_off = {3'h0, awaddr_reg[8:0]};
	assign wr_ok = (int'(wr_ch) < NCH) && (awaddr_reg[11:10] == 2'h0) &&
		(wr_off == `AGC_CTRL_OFF || wr_off == `AGC_SHIFT_OFF || wr_off == `AGC_GATECNT_OFF ||
		wr_off == `AGC_PRELOAD_OFF || wr_off == `AGC_STATUS_OFF ||
		(wr_off >= `AGC_LUT_BASE && wr_off < `AGC_LUT_BASE + 12'((1 << LUT_AW) * 4)));

	logic [IW-1:0] integ_reg [NCH], integ_next [NCH];
	logic [15:0] lut_rdata [NCH];

	genvar c;
	generate
		for (c = 0; c < NCH; c++) begin : g_ch
			logic sel;
			logic [SW-1:0] mag;
			logic [SW+`AGC_DET_SHIFT-1:0] env_reg, env_next;
			logic [15:0] cnt_reg, cnt_next;
			logic gate_d_reg, edge_run_reg, edge_run_next;
			logic active;
			logic signed [IW+15:0] step;
			logic signed [IW+16:0] sum;
			assign sel = wr_fire && wr_ok && (int'(wr_ch) == c);
			assign preload_pulse[c] = sel && wr_off == `AGC_PRELOAD_OFF;
			assign lut_we[c] = sel && wr_off >= `AGC_LUT_BASE;

			always_comb begin
				mode_next[c] = mode_reg[c];
				expinh_next[c] = expinh_reg[c];
				shift_next[c] = shift_reg[c];
				gatecnt_next[c] = gatecnt_reg[c];
				if (sel && wr_off == `AGC_CTRL_OFF) begin
					mode_next[c] = wdata_reg[`AGC_CTRL_MODE_LSB +: 2];
					expinh_next[c] = wdata_reg[`AGC_CTRL_EXPINH_BIT];
				end
				if (sel && wr_off == `AGC_SHIFT_OFF) begin
					shift_next[c] = wdata_reg[3:0];
				end
				if (sel && wr_off == `AGC_GATECNT_OFF) begin
					gatecnt_next[c] = wdata_reg[15:0];
				end
			end

			// Envelope: absolute value into a one-pole lowpass
			assign mag = abs_val(sample_in[c*SW +: SW]);
			always_comb begin
				env_next = env_reg;
				if (sample_valid[c]) begin
					env_next = env_reg - (env_reg >> `AGC_DET_SHIFT) + {{`AGC_DET_SHIFT{1'b0}}, mag};
				end
			end

			agc_lut_mem #(.AW(LUT_AW), .DW(16)) u_lut (
				.aclk(aclk),
				.we(lut_we[c]),
				.waddr(awaddr_reg[2 +: LUT_AW]),
				.wdata(wdata_reg[15:0]),
				.raddr(env_reg[SW+`AGC_DET_SHIFT-1 -: LUT_AW]),
				.rdata(lut_rdata[c])
			);

			// Gate control: level follows pin, edge runs counter to terminal
			always_comb begin
				edge_run_next = edge_run_reg;
				cnt_next = cnt_reg;
				if (mode_reg[c] == 2'(agc_pkg::AGC_GATE_EDGE)) begin
					if (gate_in[c] && !gate_d_reg) begin
						edge_run_next = 1'b1;
						cnt_next = 16'h0000;
					end else if (edge_run_reg) begin
						if (cnt_reg == gatecnt_reg[c]) begin
							edge_run_next = 1'b0;
						end else begin
							cnt_next = cnt_reg + 16'h0001;
						end
					end
				end else begin
					edge_run_next = 1'b0;
				end
			end
			always_comb begin
				unique case (agc_pkg::agc_mode_t'(mode_reg[c]))
					agc_pkg::AGC_FREE_RUN: active = 1'b1;
					agc_pkg::AGC_GATE_LEVEL: active = gate_in[c];
					agc_pkg::AGC_GATE_EDGE: active = edge_run_reg;
					agc_pkg::AGC_HOLD: active = 1'b0;
				endcase
			end

			// Shifted error into a saturating integrator
			// Deadband of zero entries in the table gives the hysteresis
			assign step = IW'(0) + ((IW+16)'($signed(lut_rdata[c])) <<< shift_reg[c]);
			assign sum = $signed({1'b0, integ_reg[c]}) + step;
			always_comb begin
				integ_next[c] = integ_reg[c];
				if (preload_pulse[c] && !active) begin
					integ_next[c] = {wdata_reg[2:0], {`AGC_INT_FRAC{1'b0}}};
				end else if (active && sample_valid[c]) begin
					if (sum < 0) begin
						integ_next[c] = '0;
					end else if (sum > $signed({1'b0, {IW{1'b1}}})) begin
						integ_next[c] = '1;
					end else begin
						integ_next[c] = sum[IW-1:0];
					end
				end
			end

			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					mode_reg[c] <= 2'h0;
					expinh_reg[c] <= 1'b0;
					shift_reg[c] <= `AGC_SHIFT_RESET;
					gatecnt_reg[c] <= `AGC_GATECNT_RESET;
					env_reg <= '0;
					cnt_reg <= 16'h0000;
					gate_d_reg <= 1'b0;
					edge_run_reg <= 1'b0;
					integ_reg[c] <= '0;
					loop_active[c] <= 1'b0;
					amp_gain_word[c*3 +: 3] <= 3'h0;
					comp_exponent[c*3 +: 3] <= 3'h7;
				end else begin
					mode_reg[c] <= mode_next[c];
					expinh_reg[c] <= expinh_next[c];
					shift_reg[c] <= shift_next[c];
					gatecnt_reg[c] <= gatecnt_next[c];
					env_reg <= env_next;
					cnt_reg <= cnt_next;
					gate_d_reg <= gate_in[c];
					edge_run_reg <= edge_run_next;
					integ_reg[c] <= integ_next[c];
					loop_active[c] <= active;
					amp_gain_word[c*3 +: 3] <= integ_reg[c][IW-1 -: 3];
					comp_exponent[c*3 +: 3] <= expinh_reg[c] ? 3'h0 : ~integ_reg[c][IW-1 -: 3];
				end
			end

			a_gain_hold: assert property (@(posedge aclk) disable iff (!aresetn)
				(!active && !preload_pulse[c]) |=> $stable(integ_reg[c]))
				else $error("integrator moved while loop open");
			a_gain_follow: assert property (@(posedge aclk) disable iff (!aresetn)
				1'b1 |=> amp_gain_word[c*3 +: 3] == $past(integ_reg[c][IW-1 -: 3]))
				else $error("gain word not from integrator");
			a_free_active: assert property (@(posedge aclk) disable iff (!aresetn)
				mode_reg[c] == 2'h0 |=> loop_active[c])
				else $error("free run loop open");
			a_level_gate: assert property (@(posedge aclk) disable iff (!aresetn)
				mode_reg[c] == 2'h1 |=> loop_active[c] == $past(gate_in[c]))
				else $error("level gate mismatch");
			a_edge_start: assert property (@(posedge aclk) disable iff (!aresetn)
				(mode_reg[c] == 2'h2 && mode_next[c] == 2'h2 && gate_in[c] && !gate_d_reg) |=> edge_run_reg)
				else $error("edge did not start counter");
			a_edge_stop: assert property (@(posedge aclk) disable iff (!aresetn)
				(edge_run_reg && cnt_reg == gatecnt_reg[c] && !(gate_in[c] && !gate_d_reg)) |=> !edge_run_reg)
				else $error("counter terminal did not open loop");
			a_preload_load: assert property (@(posedge aclk) disable iff (!aresetn)
				(preload_pulse[c] && !active) |=> integ_reg[c][IW-1 -: 3] == $past(wdata_reg[2:0]))
				else $error("preload not taken");
			a_exp_comp: assert property (@(posedge aclk) disable iff (!aresetn)
				1'b1 |-> comp_exponent[c*3 +: 3] == ($past(expinh_reg[c]) ? 3'h0 : ~$past(integ_reg[c][IW-1 -: 3])))
				else $error("exponent not gain complement");
		end
	endgenerate

	// AXI4-Lite read path, one cycle answer
	logic rvalid_reg, rvalid_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [1:0] rresp_reg, rresp_next;
	assign rd_ch = s_axi_araddr[9];
	assign rd_off = {3'h0, s_axi_araddr[8:0]};
	assign s_axi_arready = !rvalid_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
	always_comb begin
		rvalid_next = rvalid_reg;
		rdata_next = rdata_reg;
		rresp_next = rresp_reg;
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_next = 1'b1;
			rdata_next = 32'h0000_0000;
			rresp_next = 2'h0;
			if (int'(rd_ch) >= NCH || s_axi_araddr[11:10] != 2'h0) begin
				rresp_next = 2'h2;
			end else if (rd_off == `AGC_CTRL_OFF) begin
				rdata_next = {29'h0, expinh_reg[rd_ch], mode_reg[rd_ch]};
			end else if (rd_off == `AGC_SHIFT_OFF) begin
				rdata_next = {28'h0, shift_reg[rd_ch]};
			end else if (rd_off == `AGC_GATECNT_OFF) begin
				rdata_next = {16'h0, gatecnt_reg[rd_ch]};
			end else if (rd_off == `AGC_PRELOAD_OFF) begin
				rdata_next = {29'h0, integ_reg[rd_ch][IW-1 -: 3]};
			end else if (rd_off == `AGC_STATUS_OFF) begin
				rdata_next = {13'h0, loop_active[rd_ch], 18'(integ_reg[rd_ch][IW-1:1])};
			end else begin
				rresp_next = 2'h2;
			end
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_next = 1'b0;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= 2'h0;
		end else begin
			rvalid_reg <= rvalid_next;
			rdata_reg <= rdata_next;
			rresp_reg <= rresp_next;
		end
	end
endmodule

// [agc_amp_model.sv]
// Amplifier and converter model feeding quarter-rate tones to the gain loop
module agc_amp_model #(
	parameter int NCH = 2
) (
	input wire logic aclk,
	input wire logic slow,
	input wire logic run,
	input wire logic [NCH*3-1:0] amp_gain_word,
	input wire logic [NCH*8-1:0] level,
	output logic [NCH*12-1:0] sample_in,
	output logic [NCH-1:0] sample_valid
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] phase = 2'h0;
	function automatic logic [11:0] conv(input logic [7:0] lv, input logic [2:0] g, input logic neg);
		int a;
		a = int'(lv) << g;
		if (a > 2047)
			a = 2047;
		return neg ? 12'(-a) : 12'(a);
	endfunction
	initial begin
		sample_in = '0;
		sample_valid = '0;
	end
	// Quarter-rate tone keeps detector ripple out of band
	always @(posedge aclk) begin
		phase <= phase + 2'h1;
		for (int c = 0; c < NCH; c++) begin
			// Quiet until the tables are written: unwritten entries would feed unknowns into the loop
			sample_valid[c] <= run && (!slow || phase[0]);
			// Junk between slow samples, never the last value
			sample_in[c*12+:12] <= (slow && !phase[0]) ? ~conv(level[c*8+:8], amp_gain_word[c*3+:3], 1'b0)
				: conv(level[c*8+:8], amp_gain_word[c*3+:3], phase[1]);
		end
	end
endmodule

// [tb_top.sv]
// Self-checking bench for the gain loop over its register bus
`include "agc_map.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [11:0] c1 = 12'h200;
	localparam logic [11:0] ctl = `AGC_CTRL_OFF;
	localparam logic [11:0] pre = `AGC_PRELOAD_OFF;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic slow = 1'b0;
	logic run = 1'b0;
	logic [15:0] level = 16'h6018;
	logic [23:0] sample_in;
	logic [1:0] sample_valid, loop_active, s_axi_bresp, s_axi_rresp;
	logic [1:0] gate_in = 2'h0;
	logic [5:0] amp_gain_word, comp_exponent;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	int mismatches = 0, comparisons = 0, cycles = 0, act = 0, t0, t2;
	logic [2:0] g;
	agc_amp_model amp (.aclk, .slow, .run, .amp_gain_word, .level, .sample_in, .sample_valid);
	agc_gain_loop uut (.aclk, .aresetn, .sample_in, .sample_valid, .gate_in, .amp_gain_word, .comp_exponent,
		.loop_active, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	always #10 aclk = ~aclk;
	task automatic print_verdict();
		$display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (loop_active[0] === 1'b1)
			act <= act + 1;
		if (cycles == 20000) begin
			mismatches++;
			print_verdict();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		chk(s_axi_bresp, er);
	endtask
	task automatic rd(input logic [11:0] a, input logic [1:0] er, input logic [31:0] ed);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		chk(s_axi_rresp, er);
		chk(s_axi_rdata, ed);
	endtask
	task automatic lut(input logic [11:0] ch, input int split, input logic [15:0] lo, input logic [15:0] hi);
		for (int i = 0; i < 64; i++)
			wr(ch + `AGC_LUT_BASE + 12'(4 * i), {16'h0, i < split ? lo : hi}, 2'h0);
	endtask
	task automatic gwait(input logic [2:0] v, output int t);
		t = 0;
		while (amp_gain_word[2:0] !== v) begin
			@(posedge aclk);
			t++;
		end
	endtask
	initial begin
		tick(6);
		aresetn <= 1'b1;
		tick(1);
		chk(amp_gain_word, 6'h00);
		chk(comp_exponent, 6'h3F);
		chk(loop_active, 2'h0);
		rd(ctl, 2'h0, `AGC_CTRL_RESET);
		wr(ctl, 3, 2'h0);
		wr(c1, 3, 2'h0);
		rd(`AGC_GATECNT_OFF, 2'h0, `AGC_GATECNT_RESET);
		rd(`AGC_SHIFT_OFF, 2'h0, `AGC_SHIFT_RESET);
		rd(12'h020, 2'h2, 0);
		rd(`AGC_LUT_BASE, 2'h2, 0);
		wr(12'h400, 1, 2'h2);
		$display("done: reset and map");
		wr(pre, 5, 2'h0);
		wr(c1 + pre, 2, 2'h0);
		tick(3);
		chk(amp_gain_word, 6'h15);
		chk(comp_exponent, 6'h2A);
		rd(pre, 2'h0, 5);
		rd(`AGC_STATUS_OFF, 2'h0, 32'h28000);
		wr(ctl, 7, 2'h0);
		tick(3);
		chk(comp_exponent, 6'h28);
		$display("done: preload and exponent");
		wr(ctl, 3, 2'h0);
		wr(pre, 0, 2'h0);
		lut(0, 64, 16'h1000, 0);
		lut(c1, 64, 0, 0);
		run <= 1'b1;
		wr(c1, 0, 2'h0);
		wr(ctl, 0, 2'h0);
		gwait(7, t0);
		tick(300);
		chk(amp_gain_word[2:0], 7);
		wr(ctl, 3, 2'h0);
		wr(pre, 0, 2'h0);
		wr(`AGC_SHIFT_OFF, 2, 2'h0);
		wr(ctl, 0, 2'h0);
		gwait(7, t2);
		chk(32'(t0 > 3 * t2 && t0 < 5 * t2), 1);
		lut(0, 64, 16'hF000, 0);
		tick(300);
		chk(amp_gain_word[2:0], 0);
		chk(amp_gain_word[5:3], 2);
		$display("done: free run, shift, saturation");
		wr(ctl, 1, 2'h0);
		lut(0, 64, 16'h1000, 0);
		wr(pre, 1, 2'h0);
		tick(50);
		chk(amp_gain_word[2:0], 1);
		act = 0;
		gate_in <= 2'h1;
		tick(12);
		gate_in <= 2'h0;
		tick(20);
		chk(act, 12);
		g = amp_gain_word[2:0];
		tick(100);
		chk(amp_gain_word[2:0], g);
		chk(g, 4);
		$display("done: level gate");
		wr(ctl, 3, 2'h0);
		wr(pre, 0, 2'h0);
		wr(`AGC_GATECNT_OFF, 20, 2'h0);
		wr(ctl, 2, 2'h0);
		act = 0;
		gate_in <= 2'h1;
		tick(3);
		gate_in <= 2'h0;
		tick(40);
		chk(act, 21);
		chk(amp_gain_word[2:0], 5);
		$display("done: edge gate");
		wr(ctl, 3, 2'h0);
		wr(`AGC_SHIFT_OFF, 0, 2'h0);
		lut(0, 8, 16'h0400, 16'hFC00);
		lut(c1, 8, 16'h0400, 16'hFC00);
		slow <= 1'b1;
		wr(ctl, 0, 2'h0);
		tick(4000);
		repeat (10) begin
			tick(37);
			chk(32'(amp_gain_word[2:0] inside {3'h4, 3'h5}), 1);
			chk(32'(amp_gain_word[5:3] inside {3'h2, 3'h3}), 1);
		end
		$display("done: closed loop");
		print_verdict();
	end
endmodule
